// >>> verilog/ovp_top.sv
// Four overvoltage stages with settings, events, counters and pre-fault record
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Four stages, each with own settings, outputs and counters.
// - Eight groups per stage, common selector, live switching.
// - Block and active group act at run time, no restart.
// - Instant or delayed mode; delayed is definite or inverse time.
// - Start, trip, blocked outputs; ON/OFF event per change.
// - Instant start and trip events share one stamp.
// - Event stamps count milliseconds.
// - Clearable cumulative start, trip, blocked counts.
// - Six RMS line and phase magnitudes, refreshed every 5 ms.
// - Selector 0 line, 1 phase, 2 third, 3 fourth channel; default 0.
// - Line and phase use three channels, two in two-line wiring.
// - Third channel works only in two-line wiring.
// - Pre-fault record is the 20 ms average of the selection.
// - Node mode on, blocked, test, test blocked, off; default on.
// - Force status overrides outputs only under global forcing enable.
// - Node mode and force status lie outside setting groups.
// - Shared pick-up 50.00 to 150.00 percent, 0.01 steps, default 105.
// - A voltage exceeds when above the pick-up level.
// - Picked-up voltage resets only below 97 percent of pick-up.
// - Criterion 0, 1, 2 needs one, two, three voltages, capped at those available; default 0.
// - Pick-up raises start only without block; kept separate.
// - Block at pick-up gives blocked; block during start drops it.
// - Instant trip asserts in the same evaluation as start.
// - Delay type 1 definite, 2 inverse time; default definite.
module ovp_top
	import ovp_pkg::*;
#(
	parameter int TICK_CYCLES = CYCLES_PER_MS
) (
	// Clock and resets
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic por,
	// Measurements
	input wire logic meas_valid,
	input wire logic [MAG_W-1:0] line_voltage_ab,
	input wire logic [MAG_W-1:0] line_voltage_bc,
	input wire logic [MAG_W-1:0] line_voltage_ca,
	input wire logic [MAG_W-1:0] phase_voltage_a,
	input wire logic [MAG_W-1:0] phase_voltage_b,
	input wire logic [MAG_W-1:0] phase_voltage_c,
	input wire logic [MAG_W-1:0] third_channel_voltage,
	input wire logic [MAG_W-1:0] fourth_channel_voltage,
	input wire logic two_line_wiring_variant,
	// Setting groups
	input wire logic [2:0] active_group,
	input wire logic cfg_we,
	input wire logic [1:0] cfg_stage,
	input wire logic [2:0] cfg_group,
	input wire cfg_field_t cfg_field,
	input wire logic [MAG_W-1:0] cfg_data,
	// Per-stage static controls and global force enable
	input wire logic [NUM_STAGES-1:0] block_in,
	input wire node_mode_t [NUM_STAGES-1:0] node_behaviour_mode,
	input wire logic force_enable,
	input wire logic [NUM_STAGES-1:0][3:0] force_status,
	input wire logic [NUM_STAGES-1:0] counters_clear,
	// Stage outputs
	output logic [NUM_STAGES-1:0] start_out,
	output logic [NUM_STAGES-1:0] trip_out,
	output logic [NUM_STAGES-1:0] blocked_out,
	output logic [NUM_STAGES-1:0] pickup_active,
	output logic [NUM_STAGES-1:0][CNT_W-1:0] start_count,
	output logic [NUM_STAGES-1:0][CNT_W-1:0] trip_count,
	output logic [NUM_STAGES-1:0][CNT_W-1:0] blocked_count,
	output logic [NUM_STAGES-1:0][MAG_W-1:0] prefault_avg,
	// Event port
	output logic event_valid,
	input wire logic event_ready,
	output logic [1:0] event_stage,
	output logic [1:0] event_kind,
	output logic event_on,
	output logic [STAMP_W-1:0] event_stamp
);

	// ----------------------------------------------------------------
	// Millisecond tick and time stamp
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;
	logic [STAMP_W-1:0] ms_q, ms_d;

	always_comb begin
		tick_cnt_d = tick_cnt_q + 17'h0_0001;
		tick_d = 1'h0;
		ms_d = ms_q;
		if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt_d = '0;
			tick_d = 1'h1;
		end
		if (tick_q) begin
			ms_d = ms_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tick_cnt_q <= '0;
			tick_q <= 1'h0;
			ms_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
			ms_q <= ms_d;
		end
	end

	// ----------------------------------------------------------------
	// Setting group memory
	// ----------------------------------------------------------------
	group_t groups_q [NUM_STAGES][NUM_GROUPS];
	group_t groups_d [NUM_STAGES][NUM_GROUPS];
	group_t wr_grp;

	always_comb begin
		groups_d = groups_q;
		wr_grp = groups_q[cfg_stage][cfg_group];
		case (cfg_field)
			FLD_PICKUP: begin
				if (cfg_data < PICKUP_MIN) begin
					wr_grp.pickup = PICKUP_MIN;
				end else if (cfg_data > PICKUP_MAX) begin
					wr_grp.pickup = PICKUP_MAX;
				end else begin
					wr_grp.pickup = cfg_data;
				end
			end
			FLD_CRIT: begin
				if (cfg_data[1:0] != 2'h3) begin
					wr_grp.crit = crit_t'(cfg_data[1:0]);
				end
			end
			FLD_SEL: begin
				wr_grp.sel = mag_sel_t'(cfg_data[1:0]);
			end
			FLD_INSTANT: begin
				wr_grp.instant = cfg_data[0];
			end
			FLD_DTYPE: begin
				if (cfg_data[1:0] == DELAY_DT || cfg_data[1:0] == DELAY_IDMT) begin
					wr_grp.dtype = delay_t'(cfg_data[1:0]);
				end
			end
			FLD_DELAY: begin
				wr_grp.delay_ms = cfg_data;
			end
			FLD_IDMT_K: begin
				wr_grp.idmt_k = cfg_data;
			end
			default: begin
				wr_grp = groups_q[cfg_stage][cfg_group];
			end
		endcase
		if (cfg_we) begin
			groups_d[cfg_stage][cfg_group] = wr_grp;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int s = 0; s < NUM_STAGES; s++) begin
				for (int k = 0; k < NUM_GROUPS; k++) begin
					groups_q[s][k] <= GROUP_DEFAULT;
				end
			end
		end else begin
			groups_q <= groups_d;
		end
	end

	// ----------------------------------------------------------------
	// Stages and magnitude selection
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] cur;
	logic [NUM_STAGES-1:0][MAG_W-1:0] sel_max;
	logic [CNT_W-1:0] cnt_q [NUM_EVT];
	logic [NUM_STAGES-1:0][MAG_W-1:0] pre_q, pre_d;

	for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
		stage_if sif ();
		logic [MAG_W-1:0] m;

		always_comb begin
			sif.mag = '0;
			sif.avail = 2'h0;
			case (sif.grp.sel)
				SEL_LINE: begin
					sif.mag = {line_voltage_ca, line_voltage_bc, line_voltage_ab};
					sif.avail = two_line_wiring_variant ? 2'h2 : 2'h3;
				end
				SEL_PHASE: begin
					sif.mag = {phase_voltage_c, phase_voltage_b, phase_voltage_a};
					sif.avail = two_line_wiring_variant ? 2'h2 : 2'h3;
				end
				THIRD_CHANNEL_SELECT: begin
					sif.mag[0] = third_channel_voltage;
					sif.avail = two_line_wiring_variant ? 2'h1 : 2'h0;
				end
				FOURTH_CHANNEL_SELECT: begin
					sif.mag[0] = fourth_channel_voltage;
					sif.avail = 2'h1;
				end
				default: begin
					sif.avail = 2'h0;
				end
			endcase
			m = '0;
			for (int i = 0; i < NUM_VOLTS; i++) begin
				if (2'(i) < sif.avail && sif.mag[i] > m) begin
					m = sif.mag[i];
				end
			end
		end

		assign sif.grp = groups_q[g][active_group];
		assign sif.eval = meas_valid;
		assign sif.tick = tick_q;
		assign sif.block_in = block_in[g];
		assign sif.mode = node_behaviour_mode[g];
		assign sif.force_en = force_enable;
		assign sif.force_status = force_status[g];
		assign sel_max[g] = m;
		assign cur[g * NUM_KINDS + KIND_START] = sif.start;
		assign cur[g * NUM_KINDS + KIND_TRIP] = sif.trip;
		assign cur[g * NUM_KINDS + KIND_BLOCKED] = sif.blocked;
		assign start_out[g] = sif.start;
		assign trip_out[g] = sif.trip;
		assign blocked_out[g] = sif.blocked;
		assign pickup_active[g] = sif.picked;
		assign start_count[g] = cnt_q[g * NUM_KINDS + KIND_START];
		assign trip_count[g] = cnt_q[g * NUM_KINDS + KIND_TRIP];
		assign blocked_count[g] = cnt_q[g * NUM_KINDS + KIND_BLOCKED];
		assign prefault_avg[g] = pre_q[g];

		ovp_stage_core u_core (
			.sys_clk(sys_clk),
			.rst(rst),
			.sif(sif)
		);
	end

	// ----------------------------------------------------------------
	// Edge detect and cumulative counters
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] prev_q;
	logic [NUM_EVT-1:0] chg, rise;
	logic [CNT_W-1:0] cnt_d [NUM_EVT];

	always_comb begin
		chg = cur ^ prev_q;
		rise = cur & ~prev_q;
		for (int i = 0; i < NUM_EVT; i++) begin
			cnt_d[i] = counters_clear[i / NUM_KINDS] ? '0 : cnt_q[i];
			cnt_d[i] = cnt_d[i] + CNT_W'(rise[i]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_q <= '0;
		end else begin
			prev_q <= cur;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (por) begin
			for (int i = 0; i < NUM_EVT; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Pre-fault history and average
	// ----------------------------------------------------------------
	logic [MAG_W-1:0] hist_q [NUM_STAGES][HIST_DEPTH];
	logic [MAG_W-1:0] hist_d [NUM_STAGES][HIST_DEPTH];
	logic [MAG_W+1:0] hsum;

	always_comb begin
		hist_d = hist_q;
		pre_d = pre_q;
		hsum = '0;
		for (int s = 0; s < NUM_STAGES; s++) begin
			hsum = '0;
			for (int j = 0; j < HIST_DEPTH; j++) begin
				hsum = hsum + (MAG_W + 2)'(hist_q[s][j]);
			end
			if (rise[s * NUM_KINDS + KIND_START] || rise[s * NUM_KINDS + KIND_TRIP]) begin
				pre_d[s] = MAG_W'(hsum >> HIST_SHIFT);
			end
			if (meas_valid) begin
				for (int j = HIST_DEPTH - 1; j > 0; j--) begin
					hist_d[s][j] = hist_q[s][j - 1];
				end
				hist_d[s][0] = sel_max[s];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int s = 0; s < NUM_STAGES; s++) begin
				for (int j = 0; j < HIST_DEPTH; j++) begin
					hist_q[s][j] <= '0;
				end
			end
			pre_q <= '0;
		end else begin
			hist_q <= hist_d;
			pre_q <= pre_d;
		end
	end

	// ----------------------------------------------------------------
	// Event queue toward the shared event buffer
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] pend_q, pend_d, lvl_q, lvl_d;
	logic [STAMP_W-1:0] stamp_q [NUM_EVT];
	logic [STAMP_W-1:0] stamp_d [NUM_EVT];
	logic ev_valid_q, ev_valid_d, ev_on_q, ev_on_d;
	logic [1:0] ev_stage_q, ev_stage_d, ev_kind_q, ev_kind_d;
	logic [STAMP_W-1:0] ev_stamp_q, ev_stamp_d;
	logic [EVT_IDX_W-1:0] sel_idx;
	logic any, load;

	always_comb begin
		pend_d = pend_q;
		lvl_d = lvl_q;
		stamp_d = stamp_q;
		ev_valid_d = ev_valid_q;
		ev_on_d = ev_on_q;
		ev_stage_d = ev_stage_q;
		ev_kind_d = ev_kind_q;
		ev_stamp_d = ev_stamp_q;
		sel_idx = '0;
		any = 1'h0;
		for (int i = NUM_EVT - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				sel_idx = EVT_IDX_W'(i);
				any = 1'h1;
			end
		end
		load = !ev_valid_q || event_ready;
		if (load) begin
			ev_valid_d = any;
			if (any) begin
				pend_d[sel_idx] = 1'h0;
				ev_on_d = lvl_q[sel_idx];
				ev_stamp_d = stamp_q[sel_idx];
				ev_stage_d = 2'(sel_idx / EVT_IDX_W'(NUM_KINDS));
				ev_kind_d = 2'(sel_idx % EVT_IDX_W'(NUM_KINDS));
			end
		end
		for (int i = 0; i < NUM_EVT; i++) begin
			if (chg[i]) begin
				pend_d[i] = 1'h1;
				lvl_d[i] = cur[i];
				stamp_d[i] = ms_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_q <= '0;
			lvl_q <= '0;
			for (int i = 0; i < NUM_EVT; i++) begin
				stamp_q[i] <= '0;
			end
			ev_valid_q <= 1'h0;
			ev_on_q <= 1'h0;
			ev_stage_q <= 2'h0;
			ev_kind_q <= 2'h0;
			ev_stamp_q <= '0;
		end else begin
			pend_q <= pend_d;
			lvl_q <= lvl_d;
			stamp_q <= stamp_d;
			ev_valid_q <= ev_valid_d;
			ev_on_q <= ev_on_d;
			ev_stage_q <= ev_stage_d;
			ev_kind_q <= ev_kind_d;
			ev_stamp_q <= ev_stamp_d;
		end
	end

	assign event_valid = ev_valid_q;
	assign event_on = ev_on_q;
	assign event_stage = ev_stage_q;
	assign event_kind = ev_kind_q;
	assign event_stamp = ev_stamp_q;

endmodule
`default_nettype wire

// >>> verilog/ovp_pkg.sv
// Shared constants, types and defaults for the overvoltage stages
package ovp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_STAGES = 4;
	localparam int NUM_GROUPS = 8;
	localparam int NUM_VOLTS = 3;
	localparam int NUM_KINDS = 3;
	localparam int NUM_EVT = NUM_STAGES * NUM_KINDS;
	localparam int EVT_IDX_W = 4;
	localparam int MAG_W = 16;
	localparam int DELAY_W = 16;
	localparam int CNT_W = 16;
	localparam int STAMP_W = 32;
	localparam int ACC_W = 40;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_PERIOD_NS = 1_000_000;
	localparam int CYCLES_PER_MS = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int SAMPLE_PERIOD_MS = 5;
	localparam int PREFAULT_WINDOW_MS = 20;
	localparam int HIST_DEPTH = PREFAULT_WINDOW_MS / SAMPLE_PERIOD_MS;
	localparam int HIST_SHIFT = 2;

	// ----------------------------------------------------------------
	// Pick-up level, units of 0.01 percent of nominal
	// ----------------------------------------------------------------
	localparam logic [MAG_W-1:0] PICKUP_MIN = 16'h1388;
	localparam logic [MAG_W-1:0] PICKUP_MAX = 16'h3a98;
	localparam logic [MAG_W-1:0] PICKUP_DEF = 16'h2904;
	localparam logic [7:0] RESET_NUM = 8'h61;
	localparam logic [7:0] RESET_DEN = 8'h64;
	localparam logic [DELAY_W-1:0] DELAY_DEF = 16'h0064;
	localparam logic [DELAY_W-1:0] IDMT_K_DEF = 16'h0064;

	// ----------------------------------------------------------------
	// Output and force bit positions
	// ----------------------------------------------------------------
	localparam int KIND_START = 0;
	localparam int KIND_TRIP = 1;
	localparam int KIND_BLOCKED = 2;
	localparam int FORCE_ON_BIT = 3;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_LINE = 2'h0,
		SEL_PHASE = 2'h1,
		THIRD_CHANNEL_SELECT = 2'h2,
		FOURTH_CHANNEL_SELECT = 2'h3
	} mag_sel_t;

	typedef enum logic [1:0] {
		CRIT_ONE = 2'h0,
		CRIT_TWO = 2'h1,
		CRIT_THREE = 2'h2
	} crit_t;

	typedef enum logic [1:0] {
		DELAY_DT = 2'h1,
		DELAY_IDMT = 2'h2
	} delay_t;

	typedef enum logic [2:0] {
		MODE_ON = 3'h1,
		MODE_BLOCKED = 3'h2,
		MODE_TEST = 3'h3,
		MODE_TEST_BLOCKED = 3'h4,
		MODE_OFF = 3'h5
	} node_mode_t;

	typedef enum logic [2:0] {
		FLD_PICKUP = 3'h0,
		FLD_CRIT = 3'h1,
		FLD_SEL = 3'h2,
		FLD_INSTANT = 3'h3,
		FLD_DTYPE = 3'h4,
		FLD_DELAY = 3'h5,
		FLD_IDMT_K = 3'h6
	} cfg_field_t;

	typedef struct packed {
		logic [MAG_W-1:0] pickup;
		crit_t crit;
		mag_sel_t sel;
		logic instant;
		delay_t dtype;
		logic [DELAY_W-1:0] delay_ms;
		logic [DELAY_W-1:0] idmt_k;
	} group_t;

	localparam group_t GROUP_DEFAULT = '{
		pickup: PICKUP_DEF,
		crit: CRIT_ONE,
		sel: SEL_LINE,
		instant: 1'h0,
		dtype: DELAY_DT,
		delay_ms: DELAY_DEF,
		idmt_k: IDMT_K_DEF
	};

endpackage

// >>> verilog/stage_if.sv
// Signals between the stage wrapper and one stage decision core
`timescale 1ns/10ps
`default_nettype none
interface stage_if;
	import ovp_pkg::*;
	logic eval;
	logic tick;
	logic block_in;
	logic force_en;
	logic [3:0] force_status;
	node_mode_t mode;
	group_t grp;
	logic [NUM_VOLTS-1:0][MAG_W-1:0] mag;
	logic [1:0] avail;
	logic start;
	logic trip;
	logic blocked;
	logic picked;
	modport core (
		input eval, tick, block_in, force_en, force_status, mode, grp, mag, avail,
		output start, trip, blocked, picked
	);
	modport top (
		output eval, tick, block_in, force_en, force_status, mode, grp, mag, avail,
		input start, trip, blocked, picked
	);
endinterface
`default_nettype wire

// >>> verilog/ovp_stage_core.sv
// Pick-up, blocking, delay and output decision of one stage
`timescale 1ns/10ps
`default_nettype none
module ovp_stage_core
	import ovp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Stage signals
	stage_if.core sif
);

	logic [NUM_VOLTS-1:0] exceed_q, exceed_d;
	logic picked_q, picked_d, start_q, start_d, trip_q, trip_d, blocked_q, blocked_d;
	logic [NUM_KINDS-1:0] out_q, out_d;
	logic [DELAY_W-1:0] timer_q, timer_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [MAG_W+7:0] reset_prod;
	logic [MAG_W-1:0] reset_lvl, max_mag;
	logic [ACC_W-1:0] trip_lvl;
	logic [1:0] num_exc, need;
	logic block_eff, off, pick, force_on;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		reset_prod = sif.grp.pickup * RESET_NUM;
		reset_lvl = MAG_W'(reset_prod / RESET_DEN);
		trip_lvl = ACC_W'(sif.grp.idmt_k) * ACC_W'(sif.grp.pickup);
		off = sif.mode == MODE_OFF;
		block_eff = sif.block_in || sif.mode == MODE_BLOCKED || sif.mode == MODE_TEST_BLOCKED;
		exceed_d = exceed_q;
		num_exc = 2'h0;
		max_mag = '0;
		for (int i = 0; i < NUM_VOLTS; i++) begin
			if (2'(i) >= sif.avail || off) begin
				exceed_d[i] = 1'h0;
			end else if (sif.eval) begin
				if (exceed_q[i]) begin
					exceed_d[i] = !(sif.mag[i] < reset_lvl);
				end else begin
					exceed_d[i] = sif.mag[i] > sif.grp.pickup;
				end
			end
			num_exc = num_exc + 2'(exceed_d[i]);
			if (2'(i) < sif.avail && sif.mag[i] > max_mag) begin
				max_mag = sif.mag[i];
			end
		end
		need = 2'(sif.grp.crit) + 2'h1;
		if (need > sif.avail) begin
			need = sif.avail;
		end
		pick = sif.avail != 2'h0 && num_exc >= need;
		picked_d = picked_q;
		start_d = start_q;
		blocked_d = blocked_q;
		trip_d = trip_q;
		timer_d = timer_q;
		acc_d = acc_q;
		if (sif.eval) begin
			picked_d = pick;
			start_d = pick && !block_eff;
			blocked_d = pick && block_eff;
		end
		if (!start_d) begin
			trip_d = 1'h0;
			timer_d = '0;
			acc_d = '0;
		end else if (sif.grp.instant) begin
			if (sif.eval) begin
				trip_d = 1'h1;
			end
		end else if (sif.tick && !trip_q) begin
			if (sif.grp.dtype == DELAY_IDMT) begin
				if (max_mag > sif.grp.pickup) begin
					acc_d = acc_q + ACC_W'(max_mag - sif.grp.pickup);
				end
				if (acc_d >= trip_lvl) begin
					trip_d = 1'h1;
				end
			end else begin
				timer_d = timer_q + 16'h0001;
				if (timer_d >= sif.grp.delay_ms) begin
					trip_d = 1'h1;
				end
			end
		end
		if (off) begin
			picked_d = 1'h0;
			start_d = 1'h0;
			blocked_d = 1'h0;
			trip_d = 1'h0;
			timer_d = '0;
			acc_d = '0;
		end
		force_on = sif.force_en && sif.force_status[FORCE_ON_BIT];
		out_d[KIND_START] = start_d;
		out_d[KIND_TRIP] = trip_d;
		out_d[KIND_BLOCKED] = blocked_d;
		if (force_on) begin
			out_d = sif.force_status[NUM_KINDS-1:0];
		end else if (off) begin
			out_d = '0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			exceed_q <= '0;
			picked_q <= 1'h0;
			start_q <= 1'h0;
			trip_q <= 1'h0;
			blocked_q <= 1'h0;
			out_q <= '0;
			timer_q <= '0;
			acc_q <= '0;
		end else begin
			exceed_q <= exceed_d;
			picked_q <= picked_d;
			start_q <= start_d;
			trip_q <= trip_d;
			blocked_q <= blocked_d;
			out_q <= out_d;
			timer_q <= timer_d;
			acc_q <= acc_d;
		end
	end

	assign sif.start = out_q[KIND_START];
	assign sif.trip = out_q[KIND_TRIP];
	assign sif.blocked = out_q[KIND_BLOCKED];
	assign sif.picked = picked_q;

endmodule
`default_nettype wire

// >>> verification/ovp_props.sv
// Port checker for the overvoltage stage block
`timescale 1ns/10ps
`default_nettype none
module ovp_props
	import ovp_pkg::*;
#(
	parameter int TICK_CYCLES = CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Controls
	input wire logic meas_valid,
	input wire logic [NUM_STAGES-1:0] block_in,
	input wire logic force_enable,
	input wire logic [NUM_STAGES-1:0][3:0] force_status,
	input wire logic [NUM_STAGES-1:0] counters_clear,
	input wire logic event_ready,
	// Results
	input wire logic [NUM_STAGES-1:0] start_out,
	input wire logic [NUM_STAGES-1:0] trip_out,
	input wire logic [NUM_STAGES-1:0] blocked_out,
	input wire logic [NUM_STAGES-1:0] pickup_active,
	input wire logic [NUM_STAGES-1:0][CNT_W-1:0] start_count,
	input wire logic event_valid,
	input wire logic [STAMP_W-1:0] event_stamp
);
	// ----------------------------------------
	// Stage 0, all-stage reset and event port properties
	// ----------------------------------------
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_start_on_eval: assert property (
		$changed(start_out[0]) && !$past(force_enable, 1) && !$past(force_enable, 2)
		|-> $past(meas_valid)) else $error("start off eval");
	chk_block_no_start: assert property (
		meas_valid && block_in[0] && !force_enable |=> !start_out[0])
		else $error("blocked start");
	chk_start_pickup: assert property (
		start_out[0] && !$past(force_enable, 1) && !$past(force_enable, 2)
		|-> pickup_active[0]) else $error("start no pick-up");
	chk_trip_start: assert property (
		trip_out[0] && !$past(force_enable, 1) && !$past(force_enable, 2)
		|-> start_out[0]) else $error("trip no start");
	chk_reset_clears: assert property (
		$fell(rst) |-> start_out == 4'h0 && trip_out == 4'h0 && blocked_out == 4'h0
		&& !event_valid) else $error("reset outputs");
	chk_event_holds: assert property (
		event_valid && !event_ready |=> event_valid && $stable(event_stamp))
		else $error("event dropped");
	chk_clear_counts: assert property (
		counters_clear[0] |=> start_count[0] <= 16'h0001) else $error("count kept");
	chk_force_apply: assert property (
		force_enable && force_status[0][3] |=> start_out[0] == $past(force_status[0][0])
		&& trip_out[0] == $past(force_status[0][1])) else $error("force ignored");
	chk_blocked_cause: assert property (
		$rose(blocked_out[0]) && !$past(force_enable) |-> $past(block_in[0])
		&& $past(meas_valid)) else $error("blocked no cause");
endmodule
bind ovp_top ovp_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.sys_clk, .rst, .meas_valid,
	.block_in, .force_enable, .force_status, .counters_clear, .event_ready, .start_out,
	.trip_out, .blocked_out, .pickup_active, .start_count, .event_valid, .event_stamp);
`default_nettype wire

// >>> verification/ovp_meas_src.sv
// Measurement source and event sink model
`timescale 1ns/10ps
`default_nettype none
module ovp_meas_src
	import ovp_pkg::*;
(
	// Bench side
	input wire logic sys_clk,
	input wire logic go,
	input wire logic stall,
	input wire logic [7:0][MAG_W-1:0] mag,
	// Block side
	output logic meas_valid,
	output logic [7:0][MAG_W-1:0] volt,
	output logic event_ready
);
	// ----------------------------------------
	// One-cycle sample, scrambled otherwise
	// ----------------------------------------
	initial meas_valid = 1'b0;
	initial volt = '0;
	always @(posedge sys_clk) begin
		meas_valid <= go;
		volt <= go ? mag : ~mag;
	end
	assign event_ready = !stall;
endmodule
`default_nettype wire

// >>> verification/overvoltage_protection_stage_test.sv
// Self-checking bench for the overvoltage stage block
`timescale 1ns/10ps
`default_nettype none
module overvoltage_protection_stage_test;
	import ovp_pkg::*;
	// ----------------------------------------
	// Signals, models and tasks
	// ----------------------------------------
	localparam logic [15:0] HI = 16'h2af8;
	localparam logic [15:0] Z = 16'h0;
	logic sys_clk = 1'b0, rst = 1'b1, por = 1'b1, go = 1'b0, stall = 1'b0, variant = 1'b0;
	logic cfg_we = 1'b0, force_enable = 1'b0, meas_valid, event_ready, event_valid, event_on;
	logic [2:0] active_group = 3'h0;
	logic [1:0] event_stage, event_kind;
	cfg_field_t cfg_field = FLD_PICKUP;
	logic [MAG_W-1:0] cfg_data = 16'h0;
	logic [3:0] block_in = 4'h0, counters_clear = 4'h0;
	logic [3:0] start_out, trip_out, blocked_out, pickup_active;
	node_mode_t [3:0] node_behaviour_mode = '{4{MODE_ON}};
	logic [3:0][3:0] force_status = 16'h0;
	logic [3:0][CNT_W-1:0] start_count;
	logic [7:0][MAG_W-1:0] mag = '0, volt;
	logic [STAMP_W-1:0] event_stamp;
	logic [4:0] evq[$];
	logic [STAMP_W-1:0] stq[$];
	int fails = 0, checks = 0, n;
	ovp_meas_src src (.sys_clk, .go, .stall, .mag, .meas_valid, .volt, .event_ready);
	ovp_top #(.TICK_CYCLES(10)) dut (.sys_clk, .rst, .por, .meas_valid,
		.line_voltage_ab(volt[0]), .line_voltage_bc(volt[1]), .line_voltage_ca(volt[2]),
		.phase_voltage_a(volt[3]), .phase_voltage_b(volt[4]), .phase_voltage_c(volt[5]),
		.third_channel_voltage(volt[6]), .fourth_channel_voltage(volt[7]),
		.two_line_wiring_variant(variant), .active_group, .cfg_we, .cfg_stage(2'h0),
		.cfg_group(3'h0), .cfg_field, .cfg_data, .block_in, .node_behaviour_mode,
		.force_enable, .force_status, .counters_clear, .start_out, .trip_out, .blocked_out,
		.pickup_active, .start_count, .trip_count(), .blocked_count(), .prefault_avg(),
		.event_valid, .event_ready, .event_stage, .event_kind, .event_on, .event_stamp);
	initial forever #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		if (event_valid && event_ready) begin
			evq.push_back({event_stage, event_kind, event_on});
			stq.push_back(event_stamp);
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cfg(input cfg_field_t f, input logic [15:0] d);
		cfg_field <= f;
		cfg_data <= d;
		cfg_we <= 1'b1;
		@(posedge sys_clk);
		cfg_we <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic ev(input logic [15:0] a, b, x);
		mag <= {x, x, 64'h0, b, a};
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic t_crit;
		for (int c = 0; c < 3; c++) begin
			cfg(FLD_CRIT, 16'(c));
			ev(HI, HI, Z);
			check("crit", start_out[0], c < 2);
			ev(Z, Z, Z);
		end
		cfg(FLD_CRIT, Z);
		ev(16'h2904, Z, Z);
		check("at level", start_out[0], 1'b0);
		ev(16'h2905, Z, Z);
		ev(16'h27c9, Z, Z);
		check("hold", start_out[0], 1'b1);
		ev(16'h27c8, Z, Z);
		check("release", start_out[0], 1'b0);
	endtask
	task automatic t_block;
		block_in[0] <= 1'b1;
		ev(HI, Z, Z);
		check("blocked", {blocked_out[0], start_out[0], pickup_active[0]}, 3'h5);
		block_in[0] <= 1'b0;
		ev(Z, Z, Z);
		ev(HI, Z, Z);
		check("start", start_out[0], 1'b1);
		block_in[0] <= 1'b1;
		ev(HI, Z, Z);
		check("start dropped", start_out[0], 1'b0);
		block_in[0] <= 1'b0;
		ev(Z, Z, Z);
	endtask
	task automatic t_sel;
		cfg(FLD_SEL, 16'h3);
		ev(Z, Z, HI);
		check("fourth", start_out[0], 1'b1);
		ev(Z, Z, Z);
		cfg(FLD_SEL, 16'h2);
		ev(Z, Z, HI);
		check("third off", start_out[0], 1'b0);
		variant <= 1'b1;
		ev(Z, Z, HI);
		check("third on", start_out[0], 1'b1);
		ev(Z, Z, Z);
		cfg(FLD_SEL, Z);
		cfg(FLD_CRIT, 16'h2);
		ev(HI, HI, Z);
		check("two channels", start_out[0], 1'b1);
		variant <= 1'b0;
		ev(Z, Z, Z);
		cfg(FLD_CRIT, Z);
	endtask
	task automatic t_inst;
		cfg(FLD_INSTANT, 16'h1);
		repeat (30) @(posedge sys_clk);
		evq.delete();
		stq.delete();
		stall <= 1'b1;
		ev(HI, Z, Z);
		check("instant", {start_out[0], trip_out[0]}, 2'h3);
		stall <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check("first event", evq[0], 5'h01);
		check("second event", evq[1], 5'h03);
		check("stamps", stq[0], stq[1]);
		ev(Z, Z, Z);
		cfg(FLD_INSTANT, Z);
	endtask
	task automatic t_delay;
		cfg(FLD_DELAY, 16'h3);
		cfg(FLD_DTYPE, 16'h1);
		ev(HI, Z, Z);
		for (n = 0; trip_out[0] !== 1'b1 && n < 60; n++) @(posedge sys_clk);
		check("delay", n >= 16 && n <= 32, 1'b1);
		ev(Z, Z, Z);
		check("trip drops", trip_out[0], 1'b0);
	endtask
	task automatic t_reset;
		counters_clear[0] <= 1'b1;
		@(posedge sys_clk);
		counters_clear[0] <= 1'b0;
		ev(HI, Z, Z);
		check("count", start_count[0], 16'h1);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check("reset start", start_out[0], 1'b0);
		check("count kept", start_count[0], 16'h1);
	endtask
	task automatic t_force;
		force_status <= 16'h00fd;
		repeat (3) @(posedge sys_clk);
		check("unforced", start_out[1:0], 2'h0);
		force_enable <= 1'b1;
		active_group <= 3'h2;
		repeat (3) @(posedge sys_clk);
		check("forced", {blocked_out[1:0], trip_out[1:0], start_out[1:0]}, 6'h3b);
		force_enable <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(posedge sys_clk);
		t_crit();
		t_block();
		t_sel();
		t_inst();
		t_delay();
		t_reset();
		t_force();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
